// File: logic/dac_cmd_pkg.sv
// Shared constants for the quad DAC serial command port
package dac_cmd_pkg;
  localparam int unsigned FRAME_BITS = 32;
  localparam int unsigned CMD_MSB = 27;
  localparam int unsigned ADDR_MSB = 23;
  localparam int unsigned DATA_MSB = 19;
  localparam int unsigned CHAIN_BIT = 1;
  localparam int unsigned NUM_CH = 4;
  localparam logic [3:0] ADDR_ALL = 4'hF;
  localparam logic [3:0] CMD_WRITE_IN = 4'h0;
  localparam logic [3:0] CMD_UPDATE = 4'h1;
  localparam logic [3:0] CMD_WRITE_UPD_ALL = 4'h2;
  localparam logic [3:0] CMD_WRITE_UPD = 4'h3;
  localparam logic [3:0] CMD_POWER = 4'h4;
  localparam logic [3:0] CMD_CLEAR_CODE = 4'h5;
  localparam logic [3:0] CMD_LOAD_OVR = 4'h6;
  localparam logic [3:0] CMD_RESET = 4'h7;
  localparam logic [3:0] CMD_CHAIN = 4'h8;
  localparam logic [15:0] CODE_ZERO = 16'h0000;
  localparam logic [15:0] CODE_MID = 16'h8000;
  localparam logic [15:0] CODE_FULL = 16'hFFFF;
  localparam real CLK_PERIOD_NS = 5.0;
  localparam real POR_TIME_US = 50.0;
  localparam int unsigned POR_CYCLES = int'($ceil(POR_TIME_US * 1000.0 / CLK_PERIOD_NS));
  localparam logic [4:0] LINK_HALF_DIV = 5'h08;
  localparam logic [4:0] SYNC_GAP_CYCLES = 5'h10;
  localparam logic [31:0] REG_CMD_OFFS = 32'h0000_0000;
  localparam logic [31:0] REG_CTRL_OFFS = 32'h0000_0004;
  localparam logic [31:0] REG_STAT_OFFS = 32'h0000_0008;
  localparam logic [31:0] REG_FRAMES_OFFS = 32'h0000_000C;
endpackage : dac_cmd_pkg

// File: logic/dac_link_if.sv
// Serial link between the host controller and the DAC command port
`timescale 1ns/1ps
`default_nettype none
interface dac_link_if;
  logic sclk;
  logic frame_n;
  logic sdin;
  logic serial_out;
  logic output_load_n;
  logic output_clear_n;
  modport host (output sclk, output frame_n, output sdin, output output_load_n,
    output output_clear_n, input serial_out);
  modport device (input sclk, input frame_n, input sdin, input output_load_n,
    input output_clear_n, output serial_out);
endinterface : dac_link_if
`default_nettype wire

// File: logic/pin_sync.sv
// Two-flop synchroniser for a group of asynchronous pins
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int unsigned WIDTH = 1,
  parameter logic [WIDTH-1:0] INIT = '0
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Pins in, synchronised out
  input wire logic [WIDTH-1:0] pin_in,
  output logic [WIDTH-1:0] pin_out
);
  logic [WIDTH-1:0] meta_ff;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_ff <= INIT;
      pin_out <= INIT;
    end else begin
      meta_ff <= pin_in;
      pin_out <= meta_ff;
    end
  end
endmodule : pin_sync
`default_nettype wire

// File: logic/dac_cmd_device.sv
// Device end: serial command decoder with input and DAC registers
//
// Notes on behaviour
// - Frame: 4 ignored, command, address, data
// - Code 12/14/16 bits, trailing bits ignored
// - Frame low opens; sample on falling edges
// - 32nd falling edge executes decoded command
// - 0000 writes input; 0001 updates DAC
// - 0010 write, update all; 0011 write+update
// - 0100 power, 0101 clear code, 0110 override
// - 1000 chain enable; 1001-1111 do nothing
// - Address A-D 0000-0011, 1111 all channels
// - Early frame rise discards the frame
// - Chain mode from DB1; default standalone
// - Chain: overflow bits out on rising edge
// - Host gives 32N clocks; other counts discarded
// - Frame rises after last clock to latch
// - Host pulses output-load low in chain mode
// - Reset defaults; zero or midscale by strap
// - Command 0111 soft reset like power-on
// - Load/clear ignored during 50 us reset
// - Host soft-resets after slow supply ramp
// - Load pulse copies all; held low syncs
//
// The implementer's own choices: register access over APB and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module dac_cmd_device
  import dac_cmd_pkg::*;
#(
  parameter int unsigned RES_BITS = 16,
  parameter int unsigned POR_COUNT = POR_CYCLES
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  dac_link_if.device link,
  // Strap
  input wire logic por_mid,
  // DAC state
  output logic [NUM_CH*16-1:0] dac_code,
  output logic [NUM_CH*2-1:0] power_mode,
  output logic chain_mode,
  output logic por_busy
);
  logic [5:0] s_ff;
  logic sclk_q_ff;
  logic frame_q_ff;
  logic [31:0] shift_ff;
  logic [5:0] cnt_ff;
  logic exec_ff;
  logic [31:0] word_ff;
  logic [15:0] in_ff [NUM_CH];
  logic [15:0] dac_ff [NUM_CH];
  logic [NUM_CH-1:0] ovr_ff;
  logic [1:0] pd_ff [NUM_CH];
  logic [1:0] clr_code_ff;
  logic chain_ff;
  logic [15:0] rst_code_ff;
  logic soft_rst;
  logic [$clog2(POR_COUNT+1)-1:0] por_ff;
  logic por_arm_ff;
  logic load_q_ff;
  logic clr_q_ff;
  logic serial_ff;
  logic [15:0] code_w;
  logic [15:0] clr_val;
  logic [3:0] cmd_w;
  logic [3:0] addr_w;
  logic sclk_s;
  logic frame_s;
  logic sdin_s;
  logic load_s;
  logic clr_s;
  logic mid_s;
  logic fall;
  logic rise;

  // Strap is a pin too, so it goes through the same two flops
  pin_sync #(.WIDTH(6), .INIT(6'h3E)) u_sync (
    .pclk(pclk),
    .presetn(presetn),
    .pin_in({link.sclk, link.frame_n, link.sdin, link.output_load_n, link.output_clear_n,
      por_mid}),
    .pin_out(s_ff)
  );
  assign {sclk_s, frame_s, sdin_s, load_s, clr_s, mid_s} = s_ff;
  assign fall = sclk_q_ff && !sclk_s;
  assign rise = !sclk_q_ff && sclk_s;
  assign cmd_w = word_ff[CMD_MSB -: 4];
  assign addr_w = word_ff[ADDR_MSB -: 4];
  // Short codes are left aligned so trailing bits drop off
  assign code_w = {word_ff[DATA_MSB -: RES_BITS], {(16-RES_BITS){1'b0}}};
  assign soft_rst = exec_ff && cmd_w == CMD_RESET;
  assign clr_val = (clr_code_ff == 2'h1) ? CODE_MID : (clr_code_ff == 2'h2) ? CODE_FULL : CODE_ZERO;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sclk_q_ff <= 1'b1;
      frame_q_ff <= 1'b1;
      load_q_ff <= 1'b1;
      clr_q_ff <= 1'b1;
    end else begin
      sclk_q_ff <= sclk_s;
      frame_q_ff <= frame_s;
      load_q_ff <= load_s;
      clr_q_ff <= clr_s;
    end
  end

  // Strap followed all through the count, so its level as the count runs out sets the reset code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_arm_ff <= 1'b0;
      por_ff <= '0;
      rst_code_ff <= CODE_ZERO;
    end else if (!por_arm_ff) begin
      por_arm_ff <= 1'b1;
      por_ff <= $bits(por_ff)'(POR_COUNT);
    end else if (por_ff != '0) begin
      por_ff <= por_ff - 1'b1;
      rst_code_ff <= mid_s ? CODE_MID : CODE_ZERO;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      por_busy <= 1'b1;
    end else begin
      por_busy <= !por_arm_ff || por_ff > 1;
    end
  end

  // Shift and count; a frame rise off a 32 boundary discards it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_ff <= '0;
      cnt_ff <= '0;
      exec_ff <= 1'b0;
      word_ff <= '0;
    end else begin
      exec_ff <= 1'b0;
      if (frame_s) begin
        cnt_ff <= '0;
        if (!frame_q_ff && chain_ff && cnt_ff[4:0] == 5'h00 && cnt_ff != '0) begin
          exec_ff <= 1'b1;
          word_ff <= shift_ff;
        end
      end else if (fall) begin
        shift_ff <= {shift_ff[30:0], sdin_s};
        cnt_ff <= (cnt_ff == 6'h20) ? 6'h01 : cnt_ff + 6'h01;
        if (!chain_ff && cnt_ff == 6'h1F) begin
          exec_ff <= 1'b1;
          word_ff <= {shift_ff[30:0], sdin_s};
        end
      end
    end
  end

  // Serial output moves on the rising edge, valid at the falling one
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      serial_ff <= 1'b0;
    end else if (chain_ff && !frame_s && rise) begin
      serial_ff <= shift_ff[31];
    end
  end
  assign link.serial_out = serial_ff;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      chain_ff <= 1'b0;
      clr_code_ff <= 2'h0;
      ovr_ff <= '0;
    end else if (soft_rst) begin
      chain_ff <= 1'b0;
      clr_code_ff <= 2'h0;
      ovr_ff <= '0;
    end else if (exec_ff) begin
      if (cmd_w == CMD_CHAIN) chain_ff <= word_ff[CHAIN_BIT];
      if (cmd_w == CMD_CLEAR_CODE) clr_code_ff <= word_ff[1:0];
      if (cmd_w == CMD_LOAD_OVR) ovr_ff <= word_ff[NUM_CH-1:0];
    end
  end

  generate
    for (genvar i = 0; i < NUM_CH; i++) begin : g_ch
      logic hit;
      logic wr;
      logic upd;
      assign hit = addr_w == 4'(i) || addr_w == ADDR_ALL;
      assign wr = exec_ff && hit && (cmd_w == CMD_WRITE_IN || cmd_w == CMD_WRITE_UPD_ALL
        || cmd_w == CMD_WRITE_UPD);
      // Pin low or override bit set at execution updates in step with the write
      assign upd = exec_ff && ((hit && (cmd_w == CMD_UPDATE || cmd_w == CMD_WRITE_UPD))
        || cmd_w == CMD_WRITE_UPD_ALL
        || (wr && (ovr_ff[i] || !load_s)));
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          in_ff[i] <= CODE_ZERO;
          dac_ff[i] <= CODE_ZERO;
          pd_ff[i] <= 2'h0;
        end else if (por_busy && por_ff == 1 || soft_rst) begin
          in_ff[i] <= rst_code_ff;
          dac_ff[i] <= rst_code_ff;
          pd_ff[i] <= 2'h0;
        end else if (!por_busy && clr_q_ff && !clr_s && clr_code_ff != 2'h3) begin
          in_ff[i] <= clr_val;
          dac_ff[i] <= clr_val;
        end else begin
          if (wr) in_ff[i] <= code_w;
          if (upd) dac_ff[i] <= wr ? code_w : in_ff[i];
          else if (!por_busy && load_q_ff && !load_s) dac_ff[i] <= in_ff[i];
          if (exec_ff && cmd_w == CMD_POWER && word_ff[i]) pd_ff[i] <= word_ff[9:8];
        end
      end
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          dac_code[i*16 +: 16] <= CODE_ZERO;
          power_mode[i*2 +: 2] <= 2'h0;
        end else begin
          dac_code[i*16 +: 16] <= dac_ff[i];
          power_mode[i*2 +: 2] <= pd_ff[i];
        end
      end
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) chain_mode <= 1'b0;
    else chain_mode <= chain_ff;
  end
endmodule : dac_cmd_device
`default_nettype wire

// File: logic/dac_cmd_host.sv
// Host end: APB-programmed frame sender for the DAC link
`timescale 1ns/1ps
`default_nettype none
module dac_cmd_host
  import dac_cmd_pkg::*;
#(
  parameter int unsigned MAX_DEV = 4
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Link
  dac_link_if.host link
);
  typedef enum logic [1:0] {IDLE, LOW, HIGH, GAP} st_t;
  st_t st_ff;
  logic [31:0] word_ff;
  logic [31:0] sh_ff;
  logic [3:0] ndev_ff;
  logic [7:0] bits_ff;
  logic [4:0] div_ff;
  logic go_ff;
  logic load_ff;
  logic clr_ff;
  logic [1:0] so_sync_ff;
  logic [31:0] got_ff;
  logic acc;

  assign acc = psel && penable;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= '0;
    end else begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      prdata <= '0;
      if (psel && !penable) begin
        if (paddr == REG_CMD_OFFS) prdata <= word_ff;
        else if (paddr == REG_CTRL_OFFS) prdata <= {28'h0, ndev_ff};
        else if (paddr == REG_STAT_OFFS) prdata <= {31'h0, st_ff != IDLE || go_ff};
        else if (paddr == REG_FRAMES_OFFS) prdata <= got_ff;
        else pslverr <= 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_ff <= '0;
      ndev_ff <= 4'h1;
      go_ff <= 1'b0;
      load_ff <= 1'b1;
      clr_ff <= 1'b1;
    end else begin
      if (st_ff == IDLE && go_ff) go_ff <= 1'b0;
      if (acc && pready && pwrite) begin
        if (paddr == REG_CMD_OFFS) begin
          word_ff <= pwdata;
          go_ff <= 1'b1;
        end else if (paddr == REG_CTRL_OFFS) begin
          // Clamped so the burst length never overflows the bit counter
          if (pwdata[3:0] == 4'h0) ndev_ff <= 4'h1;
          else if (pwdata[3:0] > 4'(MAX_DEV)) ndev_ff <= 4'(MAX_DEV);
          else ndev_ff <= pwdata[3:0];
          load_ff <= !pwdata[8];
          clr_ff <= !pwdata[9];
        end
      end
    end
  end

  // Link clock derived by dividing pclk; bursts are exactly 32N edges
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_ff <= IDLE;
      sh_ff <= '0;
      bits_ff <= '0;
      div_ff <= '0;
    end else begin
      case (st_ff)
        IDLE: if (go_ff) begin
          st_ff <= HIGH;
          sh_ff <= word_ff;
          bits_ff <= 8'(ndev_ff) * 8'd32;
          div_ff <= '0;
        end
        HIGH: if (div_ff == LINK_HALF_DIV) begin
          div_ff <= '0;
          if (bits_ff == '0) st_ff <= GAP;
          else st_ff <= LOW;
        end else div_ff <= div_ff + 5'h01;
        LOW: if (div_ff == LINK_HALF_DIV) begin
          div_ff <= '0;
          st_ff <= HIGH;
          sh_ff <= {sh_ff[30:0], sh_ff[31]};
          bits_ff <= bits_ff - 8'd1;
        end else div_ff <= div_ff + 5'h01;
        GAP: if (div_ff == SYNC_GAP_CYCLES) st_ff <= IDLE;
        else div_ff <= div_ff + 5'h01;
        default: st_ff <= IDLE;
      endcase
    end
  end

  // Serial return sampled through two flops, captured near each falling edge
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      so_sync_ff <= '0;
      got_ff <= '0;
    end else begin
      so_sync_ff <= {so_sync_ff[0], link.serial_out};
      if (st_ff == HIGH && div_ff == LINK_HALF_DIV && bits_ff != '0) begin
        got_ff <= {got_ff[30:0], so_sync_ff[1]};
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      link.sclk <= 1'b1;
      link.frame_n <= 1'b1;
      link.sdin <= 1'b0;
      link.output_load_n <= 1'b1;
      link.output_clear_n <= 1'b1;
    end else begin
      link.sclk <= !(st_ff == LOW);
      link.frame_n <= !(st_ff == LOW || (st_ff == HIGH && !(bits_ff == '0 && div_ff != '0)));
      link.sdin <= sh_ff[31];
      link.output_load_n <= load_ff;
      link.output_clear_n <= clr_ff;
    end
  end
endmodule : dac_cmd_host
`default_nettype wire

// File: test/dac_link_props.sv
// Concurrent checks on the DAC link and the device state
`timescale 1ns/1ps
`default_nettype none
module dac_link_props #(
  parameter int unsigned POR_COUNT = 20
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // Link
  input wire logic sclk,
  input wire logic frame_n,
  input wire logic sdin,
  input wire logic serial_out,
  input wire logic output_load_n,
  input wire logic output_clear_n,
  // Device state
  input wire logic por_busy,
  input wire logic [63:0] dac_code
);
  logic [4:0] prev_ff;
  logic [7:0] edges_ff;
  logic [7:0] since_ff;
  logic [15:0] por_ff;
  logic cause;
  // Only these events may legally move a DAC code
  assign cause = (prev_ff[4] & ~sclk & ~frame_n) | (~prev_ff[3] & frame_n) |
    (prev_ff[2] & ~output_load_n) | (prev_ff[1] & ~output_clear_n) | (prev_ff[0] & ~por_busy);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) prev_ff <= 5'h1F;
    else prev_ff <= {sclk, frame_n, output_load_n, output_clear_n, por_busy};
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) edges_ff <= 8'h00;
    else if (frame_n) edges_ff <= 8'h00;
    else if (prev_ff[4] && !sclk) edges_ff <= edges_ff + 8'h01;
  end
  // Saturates so a long idle spell never wraps into a false cause
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) since_ff <= 8'hFF;
    else if (cause) since_ff <= 8'h00;
    else if (since_ff != 8'hFF) since_ff <= since_ff + 8'h01;
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) por_ff <= 16'h0000;
    else if (por_busy) por_ff <= por_ff + 16'h0001;
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sclk_idle_a: assert property ($fell(frame_n) |-> sclk)
    else $error("frame opened with link clock low");
  half_period_a: assert property ($changed(sclk) |=> $stable(sclk) [*8])
    else $error("link clock half period too short");
  sclk_frozen_a: assert property (frame_n && $past(frame_n) |-> $stable(sclk))
    else $error("link clock moved outside a frame");
  frame_gap_a: assert property ($rose(frame_n) |=> frame_n [*8])
    else $error("frame gap too short");
  frame_len_a: assert property ($rose(frame_n) |-> edges_ff != 8'h00 && edges_ff[4:0] == 5'h00)
    else $error("frame closed off a multiple of 32 edges");
  sdin_hold_a: assert property ($fell(sclk) && !frame_n |-> $stable(sdin))
    else $error("data moved at the sampling edge");
  sout_edge_a: assert property (!frame_n && $changed(serial_out) |-> sclk)
    else $error("serial out changed in the low phase");
  por_len_a: assert property (por_busy |-> por_ff <= 16'(POR_COUNT + 2))
    else $error("power-on interval too long");
  por_end_a: assert property ($fell(por_busy) |-> por_ff + 16'h0002 >= 16'(POR_COUNT))
    else $error("power-on interval too short");
  por_code_a: assert property (por_busy |-> dac_code == 64'h0)
    else $error("codes moved during power-on");
  dac_cause_a: assert property ($changed(dac_code) |-> since_ff <= 8'h0C)
    else $error("code changed without a cause");
endmodule : dac_link_props
`default_nettype wire

// File: test/quad_dac_serial_command_port_tb.sv
// Bench joining the host and device ends of the DAC link
`timescale 1ns/1ps
`default_nettype none
module quad_dac_serial_command_port_tb import dac_cmd_pkg::*;;
  localparam int unsigned POR_SIM = 20;
  logic pclk = 1'h0;
  logic presetn = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [31:0] paddr = 32'h0;
  logic [31:0] pwdata = 32'h0;
  logic por_mid = 1'h1;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [63:0] dac_code;
  logic [7:0] power_mode;
  logic [3:0] ovr_m = 4'h0;
  logic [31:0] prev_w;
  logic chain_mode;
  logic por_busy;
  logic [63:0] prev_code = 64'h0;
  logic [63:0] exp_q[$];
  logic [15:0] in_m[4];
  logic [15:0] dac_m[4];
  logic [31:0] rd;
  logic [31:0] last_w;
  logic [31:0] ctl_v = 32'h0;
  logic err;
  logic [1:0] clr_sel = 2'h0;
  int failures = 0;
  int cmp_count = 0;
  dac_link_if link ();
  dac_cmd_host #(.MAX_DEV(4)) i_dac_cmd_host (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.host));
  dac_cmd_device #(.RES_BITS(16), .POR_COUNT(POR_SIM)) i_dac_cmd_device (.pclk(pclk),
    .presetn(presetn), .link(link.device), .por_mid(por_mid), .dac_code(dac_code),
    .power_mode(power_mode), .chain_mode(chain_mode), .por_busy(por_busy));
  dac_link_props #(.POR_COUNT(POR_SIM)) i_dac_link_props (.pclk(pclk), .presetn(presetn),
    .sclk(link.sclk), .frame_n(link.frame_n), .sdin(link.sdin), .serial_out(link.serial_out),
    .output_load_n(link.output_load_n), .output_clear_n(link.output_clear_n),
    .por_busy(por_busy), .dac_code(dac_code));
  always #2.5 pclk = ~pclk;
  task automatic check_code(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : check_code
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp);
    check_code({32'h0, got}, {32'h0, exp});
  endtask : check_reg
  function automatic logic [63:0] pack();
    return {dac_m[3], dac_m[2], dac_m[1], dac_m[0]};
  endfunction : pack
  // Entered just after a rising edge; the idle cycle at the end keeps strobes single-driven
  task automatic apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'h1;
    @(posedge pclk);
    // Only the watchdog ends a wait for the answer
    while (pready !== 1'h1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
    @(posedge pclk);
  endtask : apb
  task automatic settle();
    repeat (12) @(posedge pclk);
    check_reg(32'(exp_q.size()), 32'h0);
  endtask : settle
  task automatic send(input logic [31:0] w);
    apb(1'h1, REG_CMD_OFFS, w);
    apb(1'h0, REG_CMD_OFFS, 32'h0);
    check_reg(rd, w);
    do begin
      apb(1'h0, REG_STAT_OFFS, 32'h0);
    end while (rd[0] !== 1'h0);
    settle();
  endtask : send
  task automatic cmd(input logic [3:0] c, input logic [3:0] a, input logic [19:0] lo);
    logic [63:0] b;
    b = pack();
    for (int i = 0; i < 4; i++) begin
      if (a == ADDR_ALL || a == 4'(i)) begin
        if (c inside {CMD_WRITE_IN, CMD_WRITE_UPD_ALL, CMD_WRITE_UPD}) in_m[i] = lo[19:4];
        if (c inside {CMD_UPDATE, CMD_WRITE_UPD} || ((ctl_v[8] || ovr_m[i]) && c == CMD_WRITE_IN))
          dac_m[i] = in_m[i];
      end
      if (c == CMD_WRITE_UPD_ALL) dac_m[i] = in_m[i];
      if (c == CMD_RESET) dac_m[i] = CODE_MID;
      if (c == CMD_RESET) in_m[i] = CODE_MID;
    end
    if (c == CMD_CLEAR_CODE) clr_sel = lo[1:0];
    if (c == CMD_RESET) clr_sel = 2'h0;
    if (c == CMD_LOAD_OVR) ovr_m = lo[3:0];
    if (c == CMD_RESET) ovr_m = 4'h0;
    if (pack() !== b) exp_q.push_back(pack());
    last_w = {4'($urandom), c, a, lo};
    send(last_w);
  endtask : cmd
  // Pin events act on falling edges only, so compare with the previous setting
  task automatic ctrl(input logic [31:0] v);
    logic [63:0] b;
    logic [15:0] k;
    b = pack();
    k = clr_sel[1] ? CODE_FULL : (clr_sel[0] ? CODE_MID : CODE_ZERO);
    for (int i = 0; i < 4; i++) begin
      if (v[8] && !ctl_v[8]) dac_m[i] = in_m[i];
      if (v[9] && !ctl_v[9] && clr_sel != 2'h3) in_m[i] = k;
      if (v[9] && !ctl_v[9] && clr_sel != 2'h3) dac_m[i] = k;
    end
    ctl_v = v;
    if (pack() !== b) exp_q.push_back(pack());
    apb(1'h1, REG_CTRL_OFFS, v);
    settle();
  endtask : ctrl
  always @(posedge pclk) begin
    if (presetn && dac_code !== prev_code) begin
      if (exp_q.size() == 0) check_code(dac_code, pack());
      else check_code(dac_code, exp_q.pop_front());
    end
    prev_code <= dac_code;
  end
  task automatic tally_and_finish();
    $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : tally_and_finish
  initial begin
    repeat (80000) @(posedge pclk);
    failures++;
    tally_and_finish();
  end
  initial begin
    for (int i = 0; i < 4; i++) begin
      in_m[i] = CODE_MID;
      dac_m[i] = CODE_MID;
    end
    exp_q.push_back(pack());
    void'($urandom(32'h3cae645d));
    repeat (12) @(posedge pclk);
    presetn <= 1'h1;
    @(posedge pclk);
    // Pin events inside the power-on interval must leave the codes alone
    apb(1'h1, REG_CTRL_OFFS, 32'h0000_0300);
    apb(1'h1, REG_CTRL_OFFS, 32'h0000_0000);
    while (por_busy !== 1'h0) @(posedge pclk);
    settle();
    check_reg({31'h0, chain_mode}, 32'h0);
    for (int ch = 0; ch < 4; ch++) cmd(CMD_WRITE_UPD, 4'(ch), 20'($urandom));
    cmd(CMD_WRITE_IN, ADDR_ALL, 20'($urandom));
    cmd(CMD_UPDATE, 4'h1, 20'($urandom));
    cmd(CMD_WRITE_UPD_ALL, 4'h0, 20'($urandom));
    for (int c = 4; c < 16; c++)
      if (!(c inside {5, 7, 8})) cmd(4'(c), ADDR_ALL, c < 8 ? 20'h0 : 20'($urandom));
    cmd(CMD_UPDATE, ADDR_ALL, 20'h0);
    cmd(CMD_POWER, 4'h0, 20'h00203);
    check_reg(32'(power_mode), 32'h0000_000A);
    cmd(CMD_POWER, 4'h0, 20'h0000F);
    check_reg(32'(power_mode), 32'h0);
    // Override bit makes a plain input write reach the DAC at once
    cmd(CMD_LOAD_OVR, 4'h0, 20'h00004);
    cmd(CMD_WRITE_IN, 4'h2, 20'($urandom));
    cmd(CMD_LOAD_OVR, 4'h0, 20'h0);
    ctrl(32'h0000_0100);
    cmd(CMD_WRITE_IN, 4'h3, 20'($urandom));
    ctrl(32'h0);
    cmd(CMD_WRITE_IN, 4'h2, 20'($urandom));
    ctrl(32'h0000_0100);
    ctrl(32'h0);
    for (int k = 0; k < 4; k++) begin
      cmd(CMD_WRITE_UPD, ADDR_ALL, 20'($urandom));
      cmd(CMD_CLEAR_CODE, 4'h0, 20'(k));
      ctrl(32'h0000_0200);
      ctrl(32'h0);
    end
    cmd(CMD_CHAIN, 4'h0, 20'h1);
    check_reg({31'h0, chain_mode}, 32'h0);
    cmd(CMD_CHAIN, 4'h0, 20'h2);
    check_reg({31'h0, chain_mode}, 32'h1);
    ctrl(32'h1);
    prev_w = last_w;
    cmd(CMD_WRITE_UPD, 4'h2, 20'($urandom));
    apb(1'h0, REG_FRAMES_OFFS, 32'h0);
    // A lone device in the chain hands back the word of the frame before
    check_reg(rd, prev_w);
    cmd(CMD_RESET, 4'h0, 20'($urandom));
    check_reg({31'h0, chain_mode}, 32'h0);
    ctrl(32'h0);
    cmd(CMD_WRITE_UPD, 4'h1, 20'($urandom));
    apb(1'h0, 32'h0000_0010, 32'h0);
    check_reg({31'h0, err}, 32'h1);
    tally_and_finish();
  end
endmodule : quad_dac_serial_command_port_tb
`default_nettype wire
